//--- wdtr_consts.vh
// Purpose: Shared constants of the watchdog timer with counter readout.
// Assumes: Byte-wide register port, 8-bit offsets.
// Notes: Definitions only.
`ifndef WDTR_CONSTS_VH
`define WDTR_CONSTS_VH

// Register offsets
`define WDTR_CTRL_ADDR 8'h1C
`define WDTR_READOUT_ADDR 8'h1D
`define WDTR_STATUS_ADDR 8'h1F

// Control register fields
`define WDTR_SUPPLY_LSB 0
`define WDTR_SUPPLY_MSB 1
`define WDTR_OSC_LSB 2
`define WDTR_OSC_MSB 3
`define WDTR_CTRL_USED_W 4

// Field codes
`define WDTR_SUPPLY_PUMP 2'h1
`define WDTR_SUPPLY_REG 2'h2
`define WDTR_OSC_OFF 2'h1
`define WDTR_OSC_ON 2'h2

// Reset values
`define WDTR_SUPPLY_RST 2'h1
`define WDTR_STATUS_RST 2'h0

// Status register fields
`define WDTR_STAT_TO_BIT 0
`define WDTR_STAT_PD_BIT 1

// Instruction clock is the system clock over this ratio
`define WDTR_ICLK_RATIO 4
`define WDTR_ICLK_LAST 2'h3

// Shortest time-out ratio as a power of two
`define WDTR_MIN_LOG2 13
`define WDTR_CNT_W 16

`endif

//--- wdtr_sync.v
// Purpose: Three-stage synchroniser for a pin or foreign clock level.
// Assumes: Input is asynchronous to sys_clk.
// Notes: A change is taken once the second and third stages agree.
`timescale 1ns/10ps
`default_nettype none
module wdtr_sync #(
	parameter RST_VAL = 1'b0
) (
	input wire sys_clk,
	input wire rstn,
	input wire async_in,
	output reg level_q
);
	reg s1_q;
	reg s2_q;
	reg s3_q;

	always @(posedge sys_clk) begin
		if (!rstn) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			level_q <= RST_VAL;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Stage one never feeds logic, only stages two and three
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end
endmodule
`default_nettype wire

//--- wdtr_pdiv.v
// Purpose: Watchdog divider chain with selectable overflow length.
// Assumes: tick is a one-cycle pulse in the sys_clk domain.
// Notes: Clear wins over a tick in the same cycle.
`timescale 1ns/10ps
`default_nettype none
module wdtr_pdiv #(
	parameter CNT_W = 16,
	parameter MIN_LOG2 = 13
) (
	input wire sys_clk,
	input wire rstn,
	input wire tick,
	input wire clear,
	input wire [1:0] ratio_sel,
	output reg [CNT_W-1:0] count_q,
	output reg ovf_q
);
	localparam [4:0] MIN_L = MIN_LOG2[4:0];
	wire [4:0] span;
	wire [CNT_W-1:0] mask;
	wire reached;

	assign span = MIN_L + {3'h0, ratio_sel};
	assign mask = ~({CNT_W{1'b1}} << span);
	assign reached = ((count_q & mask) == mask);

	always @(posedge sys_clk) begin
		if (!rstn) begin
			count_q <= {CNT_W{1'b0}};
			ovf_q <= 1'b0;
		end else if (clear) begin
			count_q <= {CNT_W{1'b0}};
			ovf_q <= 1'b0;
		end else if (tick) begin
			if (reached) begin
				count_q <= {CNT_W{1'b0}};
				ovf_q <= 1'b1;
			end else begin
				count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
				ovf_q <= 1'b0;
			end
		end else begin
			ovf_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- wdtr_top.v
// Purpose: Watchdog timer with oscillator control and counter readout.
// Assumes: CPU events are one-cycle pulses on sys_clk; options are static.
// Notes: The RC oscillator output arrives as a pin and is sampled.
// What this block does
// - Counter clock is the RC oscillator or system clock divided by four.
// - Disabled watchdog still counts, reads and clears, but never resets chip.
// - Supply field bits 1:0: 10 picks regulator, all else charge pump.
// - Oscillator field bits 3:2: 01 disables, others enable; bits 7:4 reserved.
// - Oscillator disabled by field stops whatever the internal clock bit.
// - Oscillator field resets to 10 if enabled with RC clock, else 01.
// - Read-only readout register returns the upper eight bits of the counter; writes ignored.
// - Time-out ratio selectable from two to thirteen up to sixteen.
// - Overflow in normal run gives chip reset and sets time-out flag.
// - Overflow while asleep gives warm reset of program counter and stack.
// - Counter cleared by low reset pin, clear instruction or halt.
// - Single-clear option: each single clear instruction clears the counter.
// - Paired option: both paired instructions needed before the clear.
// - With instruction clock source the counter stops while asleep.
// - Enabled oscillator runs in power-down only if internal clock bit set.
// - Power-down flag set by halt, cleared by clear; time-out flag on overflow.
// - Halt clears the counter and it restarts on the clock chosen by cfg_clk_rc.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "wdtr_consts.vh"
module wdtr_top #(
	parameter CNT_W = `WDTR_CNT_W,
	parameter MIN_LOG2 = `WDTR_MIN_LOG2
) (
	input wire sys_clk,
	input wire rstn,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_we,
	input wire reg_re,
	output reg [7:0] reg_rdata,
	input wire cfg_wdt_enable,
	input wire cfg_clk_rc,
	input wire cfg_clear_pair,
	input wire [1:0] cfg_ratio_sel,
	input wire internal_clock_enable,
	input wire internal_rc_oscillator,
	input wire external_reset_input_n,
	input wire cpu_asleep,
	input wire halt_instruction,
	input wire single_clear_instruction,
	input wire paired_clear_first,
	input wire paired_clear_second,
	output wire watchdog_oscillator_enable,
	output wire watchdog_supply_select,
	output reg chip_reset,
	output reg warm_reset,
	output wire timeout_flag,
	output wire powerdown_flag
);
	reg [1:0] supply_q;
	reg [1:0] osc_q;
	reg timeout_q;
	reg pdown_q;
	reg pend_first_q;
	reg pend_second_q;
	reg [1:0] iclk_div_q;
	reg rc_prev_q;
	reg rc_run_q;
	wire rc_level;
	wire ext_rst_level;
	wire [CNT_W-1:0] count;
	wire ovf;
	wire osc_field_on;
	wire rc_edge;
	wire iclk_tick;
	wire tick;
	wire sw_clear;
	wire pair_done;
	wire cnt_clear;
	wire wr_ctrl;
	reg [7:0] rdata_d;
	reg tick_d;
	wire [1:0] supply_wr;
	wire [1:0] osc_wr;
	wire [1:0] osc_rst;
	wire iclk_wrap;
	wire rc_rise;
	wire first_hit;
	wire second_hit;
	wire single_hit;
	wire halt_clear;
	wire pin_clear;
	wire ovf_armed;
	wire ovf_awake;
	wire ovf_asleep;
	wire [7:0] ctrl_word;
	wire [7:0] readout_word;
	wire [7:0] status_word;

	// Oscillator and reset pin are foreign to sys_clk
	wdtr_sync #(
		.RST_VAL(1'b0)
	) u_rc_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.async_in(internal_rc_oscillator),
		.level_q(rc_level)
	);

	wdtr_sync #(
		.RST_VAL(1'b1)
	) u_rst_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.async_in(external_reset_input_n),
		.level_q(ext_rst_level)
	);

	assign wr_ctrl = reg_we && (reg_addr == `WDTR_CTRL_ADDR);

	assign supply_wr = reg_wdata[`WDTR_SUPPLY_MSB:`WDTR_SUPPLY_LSB];
	assign osc_wr = reg_wdata[`WDTR_OSC_MSB:`WDTR_OSC_LSB];

	// Options are sampled while reset is held
	assign osc_rst = (cfg_wdt_enable && cfg_clk_rc) ? `WDTR_OSC_ON : `WDTR_OSC_OFF;

	// Supply field keeps reserved codes as written
	always @(posedge sys_clk) begin
		if (!rstn) begin
			supply_q <= `WDTR_SUPPLY_RST;
		end else if (wr_ctrl) begin
			supply_q <= supply_wr;
		end
	end

	// Oscillator field
	always @(posedge sys_clk) begin
		if (!rstn) begin
			osc_q <= osc_rst;
		end else if (wr_ctrl) begin
			osc_q <= osc_wr;
		end
	end

	// Only code 10 selects the regulator; the reserved codes stay on the pump
	assign watchdog_supply_select = (supply_q == `WDTR_SUPPLY_REG);

	assign osc_field_on = (osc_q != `WDTR_OSC_OFF);

	// Disabled field stops the oscillator outright, internal bit ignored
	assign watchdog_oscillator_enable = osc_field_on &&
		(!cpu_asleep || internal_clock_enable);

	// Edges of the RC clock only count while it is allowed to run
	always @(posedge sys_clk) begin
		if (!rstn) begin
			rc_prev_q <= 1'b0;
			rc_run_q <= 1'b0;
		end else begin
			rc_prev_q <= rc_level;
			rc_run_q <= watchdog_oscillator_enable;
		end
	end

	assign rc_rise = rc_level && !rc_prev_q;

	assign rc_edge = rc_rise && rc_run_q;

	// Instruction clock: one tick every fourth system clock
	always @(posedge sys_clk) begin
		if (!rstn) begin
			iclk_div_q <= 2'h0;
		end else if (cnt_clear) begin
			iclk_div_q <= 2'h0;
		end else if (!cpu_asleep) begin
			iclk_div_q <= iclk_div_q + 2'h1;
		end
	end

	// System clock is stopped in sleep, so this source freezes there
	assign iclk_wrap = (iclk_div_q == `WDTR_ICLK_LAST);

	assign iclk_tick = iclk_wrap && !cpu_asleep;

	always @* begin
		tick_d = 1'b0;
		case (cfg_clk_rc)
			1'b1: begin
				tick_d = rc_edge;
			end
			default: begin
				tick_d = iclk_tick;
			end
		endcase
	end

	assign tick = tick_d;

	// Paired clear: either order, second one completes the clear
	assign first_hit = paired_clear_first && (pend_second_q || paired_clear_second);

	assign second_hit = paired_clear_second && pend_first_q;

	assign pair_done = cfg_clear_pair && (first_hit || second_hit);

	always @(posedge sys_clk) begin
		if (!rstn) begin
			pend_first_q <= 1'b0;
			pend_second_q <= 1'b0;
		end else if (!cfg_clear_pair || pair_done) begin
			pend_first_q <= 1'b0;
			pend_second_q <= 1'b0;
		end else begin
			if (paired_clear_first) begin
				pend_first_q <= 1'b1;
			end
			if (paired_clear_second) begin
				pend_second_q <= 1'b1;
			end
		end
	end

	// Single clear counts only when the single option is chosen
	assign single_hit = !cfg_clear_pair && single_clear_instruction;

	assign sw_clear = single_hit || pair_done;

	assign halt_clear = halt_instruction;

	assign pin_clear = !ext_rst_level;

	assign cnt_clear = pin_clear || sw_clear || halt_clear;

	wdtr_pdiv #(
		.CNT_W(CNT_W),
		.MIN_LOG2(MIN_LOG2)
	) u_div (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.tick(tick),
		.clear(cnt_clear),
		.ratio_sel(cfg_ratio_sel),
		.count_q(count),
		.ovf_q(ovf)
	);

	// Overflow outcome depends on sleep state; disabled option masks both
	assign ovf_armed = ovf && cfg_wdt_enable;

	assign ovf_awake = ovf_armed && !cpu_asleep;

	assign ovf_asleep = ovf_armed && cpu_asleep;

	always @(posedge sys_clk) begin
		if (!rstn) begin
			chip_reset <= 1'b0;
		end else begin
			chip_reset <= ovf_awake;
		end
	end

	always @(posedge sys_clk) begin
		if (!rstn) begin
			warm_reset <= 1'b0;
		end else begin
			warm_reset <= ovf_asleep;
		end
	end

	// Status flags: a setting event wins over a clear in the same cycle
	always @(posedge sys_clk) begin
		if (!rstn) begin
			timeout_q <= 1'b0;
		end else if (ovf_armed) begin
			timeout_q <= 1'b1;
		end else if (halt_instruction || sw_clear) begin
			timeout_q <= 1'b0;
		end
	end

	always @(posedge sys_clk) begin
		if (!rstn) begin
			pdown_q <= 1'b0;
		end else if (halt_instruction) begin
			pdown_q <= 1'b1;
		end else if (sw_clear) begin
			pdown_q <= 1'b0;
		end
	end

	assign timeout_flag = timeout_q;
	assign powerdown_flag = pdown_q;

	assign ctrl_word = {4'h0, osc_q, supply_q};

	assign readout_word = count[CNT_W-1:CNT_W-8];

	assign status_word = {6'h00, pdown_q, timeout_q};

	// Read mux; readout has no write path at all
	always @* begin
		rdata_d = 8'h00;
		case (reg_addr)
			`WDTR_CTRL_ADDR: begin
				rdata_d = ctrl_word;
			end
			`WDTR_READOUT_ADDR: begin
				rdata_d = readout_word;
			end
			`WDTR_STATUS_ADDR: begin
				rdata_d = status_word;
			end
			default: begin
				rdata_d = 8'h00;
			end
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_re) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule
`default_nettype wire

//--- wdtr_top_chk.sv
// Purpose: Port checker for the watchdog block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound from the bench top file.
`timescale 1ns/10ps
`default_nettype none
module wdtr_chk (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic [7:0] reg_rdata,
	input wire logic cfg_wdt_enable,
	input wire logic cfg_clk_rc,
	input wire logic cfg_clear_pair,
	input wire logic cpu_asleep,
	input wire logic halt_instruction,
	input wire logic paired_clear_first,
	input wire logic paired_clear_second,
	input wire logic watchdog_oscillator_enable,
	input wire logic watchdog_supply_select,
	input wire logic chip_reset,
	input wire logic timeout_flag,
	input wire logic powerdown_flag
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	wire logic ctl_wr = reg_we && reg_addr == 8'h1C;
	wire logic reg_pick = reg_wdata[1:0] == 2'h2;
	// Second half may come a few cycles after the first
	sequence s_pair;
		cfg_clear_pair && paired_clear_first && !halt_instruction ##[1:4]
		paired_clear_second && !halt_instruction;
	endsequence
	rd_idle_a:
		assert property (!$past(reg_re) |-> reg_rdata == 8'h00) else $error("stray read data");
	sup_wr_a:
		assert property (ctl_wr |=> watchdog_supply_select == $past(reg_pick))
		else $error("supply select wrong");
	osc_off_a:
		assert property (ctl_wr && reg_wdata[3:2] == 2'h1 |=> !watchdog_oscillator_enable)
		else $error("oscillator not off");
	osc_rst_a:
		assert property ($rose(rstn) && !cpu_asleep |->
			watchdog_oscillator_enable == (cfg_wdt_enable && cfg_clk_rc)) else $error("osc reset");
	rst_pulse_a:
		assert property (chip_reset |=> !chip_reset) else $error("chip reset too long");
	rst_en_a:
		assert property (chip_reset |-> cfg_wdt_enable && timeout_flag) else $error("bad chip reset");
	halt_pd_a:
		assert property (halt_instruction |=> powerdown_flag) else $error("powerdown not set");
	pair_clr_a:
		assert property (s_pair |=> !powerdown_flag) else $error("pair did not clear");
endmodule
`default_nettype wire

//--- wdtr_top_tb.sv
// Purpose: Self-checking bench for the watchdog block.
// Assumes: Short time-outs through MIN_LOG2.
// Notes: Read data is checked against a queue of expected values.
`timescale 1ns/10ps
`default_nettype none
module wdtr_top_tb;
	localparam int ML = 4;
	logic sys_clk = 0, rstn = 0, reg_we = 0, reg_re = 0, cfg_wdt_enable = 1, cfg_clk_rc = 0;
	logic cfg_clear_pair = 0, internal_clock_enable = 1, cpu_asleep = 0;
	logic external_reset_input_n = 1, rv = 0;
	logic [1:0] cfg_ratio_sel = 0;
	logic [2:0] rcd = 0;
	logic [3:0] ev = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
	logic watchdog_oscillator_enable, watchdog_supply_select;
	logic chip_reset, warm_reset, timeout_flag, powerdown_flag;
	logic [7:0] exp_q[$];
	int n_mismatch = 0, tests_run = 0, nc, nw, c;
	always #5 sys_clk = ~sys_clk;
	// Slow stand-in for the RC oscillator pin
	always @(posedge sys_clk) rcd <= rcd + 3'h1;
	wdtr_top #(.MIN_LOG2(ML)) DUT (.*, .internal_rc_oscillator(rcd[2]),
		.halt_instruction(ev[3]), .single_clear_instruction(ev[2]),
		.paired_clear_first(ev[1]), .paired_clear_second(ev[0]));
	task automatic chk(input logic [31:0] seen, want, input string nm);
		tests_run++;
		if (seen !== want) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, want, seen);
		end
	endtask
	always @(posedge sys_clk) begin
		if (rv) chk(32'(reg_rdata), 32'(exp_q.pop_front()), "reg_rdata");
		rv <= reg_re;
	end
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge sys_clk);
		reg_we <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_we <= 0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		exp_q.push_back(e);
		@(posedge sys_clk);
		reg_re <= 1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_re <= 0;
	endtask
	task automatic evp(input logic [3:0] m);
		@(posedge sys_clk);
		ev <= m;
		@(posedge sys_clk);
		ev <= 0;
		#1;
	endtask
	// First cycles skipped: an overflow may still be in flight
	task automatic run(input logic [3:0] m1, m2, input logic ec, ew);
		nc = 0;
		nw = 0;
		for (int k = 0; k < 400; k++) begin
			@(posedge sys_clk);
			ev <= (k % 40 == 0) ? m1 : (k % 40 == 20) ? m2 : 4'h0;
			if (k > 30) begin
				nc += chip_reset;
				nw += warm_reset;
			end
		end
		chk(32'(nc != 0), 32'(ec), "chip_reset");
		chk(32'(nw != 0), 32'(ew), "warm_reset");
	endtask
	initial begin
		void'($urandom(18881));
		repeat (6) @(posedge sys_clk);
		rstn <= 1;
		rd(8'h1C, 8'h05);
		rd(8'h1F, 8'h00);
		rd(8'h00, 8'h00);
		for (int i = 0; i < 16; i++) begin
			wr(8'h1C, {4'($urandom), 4'(i)});
			rd(8'h1C, {4'h0, 4'(i)});
			chk(32'(watchdog_supply_select), 32'(i[1:0] == 2'h2), "supply");
			chk(32'(watchdog_oscillator_enable), 32'(i[3:2] != 2'h1), "osc");
		end
		wr(8'h1C, 8'h09);
		wr(8'h1D, 8'hFF);
		evp(4'h4);
		rd(8'h1D, 8'h00);
		$display("test registers done");
		for (int p = 0; p < 2; p++) begin
			cfg_clear_pair <= p[0];
			evp(4'h8);
			chk(32'(powerdown_flag), 1, "pd_set");
			if (p == 1) evp(4'h2);
			evp(p == 1 ? 4'h1 : 4'h4);
			chk(32'(powerdown_flag), 0, "pd_clear");
		end
		cfg_clear_pair <= 0;
		for (int s = 0; s < 4; s++) begin
			cfg_ratio_sel <= s[1:0];
			evp(4'h4);
			c = 0;
			while (chip_reset !== 1'b1 && c < 3000) begin
				@(posedge sys_clk);
				c++;
			end
			if (c == 3000) begin
				n_mismatch++;
				end_of_test();
			end
			chk(32'(c + 4 >= (4 << (ML + s)) && c <= (4 << (ML + s)) + 8), 1, "period");
			chk(32'(timeout_flag), 1, "timeout_flag");
		end
		cfg_ratio_sel <= 0;
		$display("test timeout done");
		run(4'h4, 4'h0, 0, 0);
		external_reset_input_n <= 0;
		run(4'h0, 4'h0, 0, 0);
		external_reset_input_n <= 1;
		cfg_wdt_enable <= 0;
		run(4'h0, 4'h0, 0, 0);
		cfg_wdt_enable <= 1;
		cfg_clear_pair <= 1;
		run(4'h4, 4'h4, 1, 0);
		run(4'h2, 4'h2, 1, 0);
		run(4'h2, 4'h1, 0, 0);
		run(4'h1, 4'h2, 0, 0);
		cpu_asleep <= 1;
		run(4'h0, 4'h0, 0, 0);
		cfg_clk_rc <= 1;
		run(4'h0, 4'h0, 0, 1);
		wr(8'h1C, 8'h05);
		run(4'h0, 4'h0, 0, 0);
		$display("test clears and sleep done");
		end_of_test();
	end
endmodule
bind wdtr_top wdtr_chk chk (.*);
`default_nettype wire
